// File: src/acs_config.sv
// Purpose: Serial register port and strap decoder of a quad converter
// Assumes: Strap pins arrive as 2-bit level codes; all pins are asynchronous
// Notes: Straps govern until the override bit is set; the power-down pin forces global power down either way
`default_nettype none
module acs_config (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic reset_pin_in,
    input wire logic serial_select_n_in,
    input wire logic serial_clk_in,
    input wire logic serial_in_line_in,
    input wire logic pdn_pin_in,
    input wire logic [1:0] select_level_in,
    input wire logic [1:0] link_config_pin_in,
    input wire logic [1:0] serialization_config_pin_in,
    input wire logic [1:0] format_config_pin_in,
    output logic global_pd_out,
    output logic [3:0] chan_pd_out,
    output logic [2:0] pattern_out,
    output logic internal_ref_out,
    output logic coarse_gain_out,
    output logic ddr_clk_out,
    output logic two_wire_out,
    output logic ser14_out,
    output logic rise_capture_out,
    output logic lsb_first_out,
    output logic offset_binary_out,
    output logic byte_wise_out,
    output logic override_out,
    output logic reg_write_out,
    output logic regs_reset_out
);
    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_SHIFT = 1'b1
    } acs_rx_state_t;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [3:0] ser_s;
    logic [8:0] strap_s;
    logic rst_pin_s;
    logic sel_n_s;
    logic sclk_s;
    logic serial_in_line_s;
    logic pdn_s;
    acs_pkg::acs_level_t sel_lvl;
    acs_pkg::acs_level_t link_lvl;
    acs_pkg::acs_level_t ser_lvl;
    acs_pkg::acs_level_t fmt_lvl;

    acs_sync #(
        .WIDTH(4)
    ) u_sync_serial (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .async_in({reset_pin_in, serial_select_n_in, serial_clk_in, serial_in_line_in}),
        .sync_out(ser_s)
    );

    acs_sync #(
        .WIDTH(9)
    ) u_sync_strap (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .async_in({pdn_pin_in, select_level_in, link_config_pin_in,
                   serialization_config_pin_in, format_config_pin_in}),
        .sync_out(strap_s)
    );

    assign rst_pin_s = ser_s[3];
    assign sel_n_s = ser_s[2];
    assign sclk_s = ser_s[1];
    assign serial_in_line_s = ser_s[0];
    assign pdn_s = strap_s[8];
    assign sel_lvl = acs_pkg::acs_level_t'(strap_s[7:6]);
    assign link_lvl = acs_pkg::acs_level_t'(strap_s[5:4]);
    assign ser_lvl = acs_pkg::acs_level_t'(strap_s[3:2]);
    assign fmt_lvl = acs_pkg::acs_level_t'(strap_s[1:0]);

    // ----------------------------------------------------------------
    // Serial clock edge detection
    // ----------------------------------------------------------------
    logic sclk_prev;
    logic sclk_fall;

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            sclk_prev <= 1'b0;
        end else begin
            sclk_prev <= sclk_s;
        end
    end

    assign sclk_fall = sclk_prev && !sclk_s;

    // ----------------------------------------------------------------
    // Hardware reset pin pulse qualifier
    // ----------------------------------------------------------------
    localparam int RCW = $clog2(acs_pkg::RST_PULSE_CYC + 1);
    localparam logic [RCW-1:0] RST_CYC = RCW'(acs_pkg::RST_PULSE_CYC);
    logic [RCW-1:0] rst_pin_cnt;
    logic hw_reset;

    always_ff @(posedge ref_clk_in) begin
        if (rst_in || !rst_pin_s) begin
            rst_pin_cnt <= '0;
        end else if (rst_pin_cnt != RST_CYC) begin
            rst_pin_cnt <= rst_pin_cnt + RCW'(1);
        end
    end

    assign hw_reset = (rst_pin_cnt == RST_CYC);

    // ----------------------------------------------------------------
    // Serial receiver
    // ----------------------------------------------------------------
    acs_rx_state_t rx_state;
    acs_rx_state_t next_rx_state;
    logic [3:0] bit_cnt;
    logic [acs_pkg::WORD_BITS-1:0] shift;
    logic [acs_pkg::WORD_BITS-1:0] next_shift;
    logic word_done;

    always_comb begin
        case (rx_state)
            ST_IDLE: next_rx_state = sel_n_s ? ST_IDLE : ST_SHIFT;
            ST_SHIFT: next_rx_state = sel_n_s ? ST_IDLE : ST_SHIFT;
            default: next_rx_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rx_state <= ST_IDLE;
        end else begin
            rx_state <= next_rx_state;
        end
    end

    assign next_shift = {shift[acs_pkg::WORD_BITS-2:0], serial_in_line_s};
    assign word_done = !sel_n_s && sclk_fall && bit_cnt == acs_pkg::LAST_BIT;

    always_ff @(posedge ref_clk_in) begin
        if (rst_in || sel_n_s) begin
            bit_cnt <= 4'h0;
        end else if (sclk_fall && rx_state == ST_SHIFT) begin
            bit_cnt <= bit_cnt + 4'h1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            shift <= '0;
        end else if (rx_state == ST_SHIFT && !sel_n_s && sclk_fall) begin
            shift <= next_shift;
        end
    end

    // ----------------------------------------------------------------
    // Write delay
    // ----------------------------------------------------------------
    logic wr_fire;
    logic [acs_pkg::WORD_BITS-1:0] wr_word;
    logic [acs_pkg::ADDR_BITS-1:0] wr_addr;
    logic [acs_pkg::DATA_BITS-1:0] wr_data;
    logic sw_reset;
    logic regs_clear;

    acs_dly #(
        .WIDTH(acs_pkg::WORD_BITS),
        .DELAY(acs_pkg::APPLY_DELAY_CYC)
    ) u_dly (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .flush_in(hw_reset),
        .load_in(word_done),
        .data_in(next_shift),
        .fire_out(wr_fire),
        .data_out(wr_word)
    );

    assign wr_addr = wr_word[acs_pkg::WORD_BITS-1:acs_pkg::DATA_BITS];
    assign wr_data = wr_word[acs_pkg::DATA_BITS-1:0];
    assign sw_reset = wr_fire && wr_addr == acs_pkg::ADDR_MAIN
                      && wr_data[acs_pkg::B_SW_RESET];
    assign regs_clear = hw_reset || sw_reset;

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    logic [acs_pkg::DATA_BITS-1:0] reg_main;
    logic [acs_pkg::DATA_BITS-1:0] reg_pattern;
    logic [acs_pkg::DATA_BITS-1:0] reg_iface;

    always_ff @(posedge ref_clk_in) begin
        if (rst_in || regs_clear) begin
            reg_main <= acs_pkg::REG_RESET;
        end else if (wr_fire && wr_addr == acs_pkg::ADDR_MAIN) begin
            reg_main <= wr_data;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in || regs_clear) begin
            reg_pattern <= acs_pkg::REG_RESET;
        end else if (wr_fire && wr_addr == acs_pkg::ADDR_PATTERN) begin
            reg_pattern <= wr_data;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in || regs_clear) begin
            reg_iface <= acs_pkg::REG_RESET;
        end else if (wr_fire && wr_addr == acs_pkg::ADDR_IFACE) begin
            reg_iface <= wr_data;
        end
    end

    // ----------------------------------------------------------------
    // Strap decode
    // ----------------------------------------------------------------
    logic strap_pd;
    logic [2:0] strap_pat;
    logic strap_int_ref;
    logic strap_gain;
    logic strap_ddr;
    logic strap_two_wire;
    logic strap_ser14;
    logic strap_rise;
    logic strap_lsb;
    logic strap_offset;

    always_comb begin
        strap_pd = 1'b0;
        strap_pat = acs_pkg::PAT_NORMAL;
        case ({sclk_s, serial_in_line_s})
            2'h1: strap_pat = acs_pkg::PAT_SYNC;
            2'h2: strap_pd = 1'b1;
            2'h3: strap_pat = acs_pkg::PAT_DESKEW;
            default: strap_pat = acs_pkg::PAT_NORMAL;
        endcase
    end

    always_comb begin
        case (sel_lvl)
            acs_pkg::LVL_GND: {strap_int_ref, strap_gain} = 2'h0;
            acs_pkg::LVL_3_8: {strap_int_ref, strap_gain} = 2'h1;
            acs_pkg::LVL_5_8: {strap_int_ref, strap_gain} = 2'h3;
            default: {strap_int_ref, strap_gain} = 2'h2;
        endcase
    end

    always_comb begin
        case (link_lvl)
            acs_pkg::LVL_5_8: {strap_ddr, strap_two_wire} = 2'h1;
            acs_pkg::LVL_FULL: {strap_ddr, strap_two_wire} = 2'h3;
            default: {strap_ddr, strap_two_wire} = 2'h2;
        endcase
    end

    always_comb begin
        strap_ser14 = 1'b0;
        strap_rise = 1'b0;
        if (!strap_ddr && strap_two_wire) begin
            case (ser_lvl)
                acs_pkg::LVL_GND: {strap_ser14, strap_rise} = 2'h0;
                acs_pkg::LVL_3_8: {strap_ser14, strap_rise} = 2'h2;
                acs_pkg::LVL_5_8: {strap_ser14, strap_rise} = 2'h3;
                default: {strap_ser14, strap_rise} = 2'h1;
            endcase
        end
    end

    always_comb begin
        case (fmt_lvl)
            acs_pkg::LVL_GND: {strap_lsb, strap_offset} = 2'h0;
            acs_pkg::LVL_3_8: {strap_lsb, strap_offset} = 2'h1;
            acs_pkg::LVL_5_8: {strap_lsb, strap_offset} = 2'h3;
            default: {strap_lsb, strap_offset} = 2'h2;
        endcase
    end

    // ----------------------------------------------------------------
    // Source selection and output registers
    // ----------------------------------------------------------------
    logic ovrd;
    logic next_global_pd;

    assign ovrd = reg_iface[acs_pkg::B_OVERRIDE];
    assign next_global_pd = pdn_s
        || (ovrd ? reg_main[acs_pkg::B_PD_GLOBAL] : strap_pd);

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            global_pd_out <= 1'b0;
            chan_pd_out <= 4'h0;
            override_out <= 1'b0;
            reg_write_out <= 1'b0;
            regs_reset_out <= 1'b0;
        end else begin
            global_pd_out <= next_global_pd;
            chan_pd_out <= reg_main[acs_pkg::B_CHPD_LO +: 4];
            override_out <= ovrd;
            reg_write_out <= wr_fire;
            regs_reset_out <= regs_clear;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            pattern_out <= acs_pkg::PAT_NORMAL;
            internal_ref_out <= 1'b0;
            coarse_gain_out <= 1'b0;
        end else if (ovrd) begin
            pattern_out <= reg_pattern[acs_pkg::B_PAT_LO +: 3];
            internal_ref_out <= reg_main[acs_pkg::B_REF];
            coarse_gain_out <= reg_iface[acs_pkg::B_COARSE];
        end else begin
            pattern_out <= strap_pat;
            internal_ref_out <= strap_int_ref;
            coarse_gain_out <= strap_gain;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            ddr_clk_out <= 1'b1;
            two_wire_out <= 1'b0;
            ser14_out <= 1'b0;
            rise_capture_out <= 1'b0;
            lsb_first_out <= 1'b0;
            offset_binary_out <= 1'b0;
            byte_wise_out <= 1'b0;
        end else if (ovrd) begin
            ddr_clk_out <= !reg_iface[acs_pkg::B_SDR];
            two_wire_out <= !reg_iface[acs_pkg::B_ONE_WIRE];
            ser14_out <= reg_iface[acs_pkg::B_SER14];
            rise_capture_out <= !reg_iface[acs_pkg::B_FALL_EDGE];
            lsb_first_out <= reg_iface[acs_pkg::B_LSB_FIRST];
            offset_binary_out <= reg_pattern[acs_pkg::B_DATA_FMT];
            byte_wise_out <= reg_iface[acs_pkg::B_BYTE_WISE];
        end else begin
            ddr_clk_out <= strap_ddr;
            two_wire_out <= strap_two_wire;
            ser14_out <= strap_ser14;
            rise_capture_out <= strap_rise;
            lsb_first_out <= strap_lsb;
            offset_binary_out <= strap_offset;
            byte_wise_out <= 1'b0;
        end
    end
endmodule : acs_config
`default_nettype wire

// File: src/acs_pkg.sv
// Purpose: Shared constants for the converter configuration front end
// Assumes: 250 MHz reference clock, strap levels arrive as 2-bit comparator codes
// Notes: Register addresses and bit positions of the serial word live here
`default_nettype none
package acs_pkg;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int RST_PULSE_NS = 10;
    localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int APPLY_DELAY_NS = 100;
    localparam int APPLY_DELAY_CYC = APPLY_DELAY_NS / CLK_PERIOD_NS;
    // ----------------------------------------------------------------
    // Serial word layout
    // ----------------------------------------------------------------
    localparam int WORD_BITS = 16;
    localparam int ADDR_BITS = 5;
    localparam int DATA_BITS = 11;
    localparam logic [3:0] LAST_BIT = 4'hF;
    localparam logic [4:0] ADDR_MAIN = 5'h00;
    localparam logic [4:0] ADDR_PATTERN = 5'h0A;
    localparam logic [4:0] ADDR_IFACE = 5'h0D;
    localparam logic [10:0] REG_RESET = 11'h000;
    // Register 0x00 fields
    localparam int B_SW_RESET = 10;
    localparam int B_REF = 5;
    localparam int B_CHPD_LO = 1;
    localparam int B_PD_GLOBAL = 0;
    // Register 0x0A fields
    localparam int B_DATA_FMT = 9;
    localparam int B_PAT_LO = 5;
    // Register 0x0D fields
    localparam int B_OVERRIDE = 10;
    localparam int B_BYTE_WISE = 7;
    localparam int B_LSB_FIRST = 6;
    localparam int B_COARSE = 5;
    localparam int B_FALL_EDGE = 4;
    localparam int B_SER14 = 2;
    localparam int B_SDR = 1;
    localparam int B_ONE_WIRE = 0;
    // ----------------------------------------------------------------
    // Strap levels and output pattern codes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        LVL_GND = 2'h0,
        LVL_3_8 = 2'h1,
        LVL_5_8 = 2'h2,
        LVL_FULL = 2'h3
    } acs_level_t;
    localparam logic [2:0] PAT_NORMAL = 3'h0;
    localparam logic [2:0] PAT_SYNC = 3'h1;
    localparam logic [2:0] PAT_DESKEW = 3'h2;
endpackage : acs_pkg
`default_nettype wire

// File: src/acs_sync.sv
// Purpose: Two-stage synchroniser for pins from outside the clock domain
// Assumes: Each bit is a slow level or a clock far below the sample rate
// Notes: Only the second stage is visible to the rest of the block
`default_nettype none
module acs_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    // ----------------------------------------------------------------
    // Two flip-flop chain
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule : acs_sync
`default_nettype wire

// File: src/acs_dly.sv
// Purpose: Holds one completed word and releases it after a fixed delay
// Assumes: A new word never arrives while one is still pending
// Notes: Flush drops a pending word without releasing it
`default_nettype none
module acs_dly #(
    parameter int WIDTH = 16,
    parameter int DELAY = 25
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic flush_in,
    input wire logic load_in,
    input wire logic [WIDTH-1:0] data_in,
    output logic fire_out,
    output logic [WIDTH-1:0] data_out
);
    localparam int CW = $clog2(DELAY + 1);
    localparam logic [CW-1:0] START = CW'(DELAY);
    logic [CW-1:0] count;
    logic pending;

    // ----------------------------------------------------------------
    // Countdown and release
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (rst_in || flush_in) begin
            pending <= 1'b0;
            count <= '0;
            fire_out <= 1'b0;
            data_out <= '0;
        end else if (load_in) begin
            pending <= 1'b1;
            count <= START;
            fire_out <= 1'b0;
            data_out <= data_in;
        end else if (pending && count == CW'(1)) begin
            pending <= 1'b0;
            count <= '0;
            fire_out <= 1'b1;
        end else begin
            count <= pending ? count - CW'(1) : count;
            fire_out <= 1'b0;
        end
    end
endmodule : acs_dly
`default_nettype wire

// File: verification/acs_config_asserts.sv
// Purpose: Concurrent checks on the serial port and strap decode of acs_config
// Assumes: Pins are sampled raw on the reference clock, two stages ahead of the design
// Notes: Write timing windows allow for the design's two-stage synchronisers
`default_nettype none
module acs_config_asserts (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic reset_pin_in,
    input wire logic serial_select_n_in,
    input wire logic serial_clk_in,
    input wire logic serial_in_line_in,
    input wire logic pdn_pin_in,
    input wire logic [1:0] select_level_in,
    input wire logic [1:0] format_config_pin_in,
    input wire logic global_pd_out,
    input wire logic [2:0] pattern_out,
    input wire logic internal_ref_out,
    input wire logic coarse_gain_out,
    input wire logic lsb_first_out,
    input wire logic offset_binary_out,
    input wire logic override_out,
    input wire logic reg_write_out,
    input wire logic regs_reset_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------
    // Falling-edge bit counter
    // ------------------------------------------------------------
    logic sclk_q;
    logic [3:0] bit_cnt;
    logic [7:0] since16;
    logic fell16;
    logic strap_on;
    assign fell16 = sclk_q && !serial_clk_in && !serial_select_n_in && (bit_cnt == 4'hF);
    assign strap_on = serial_select_n_in && !override_out;
    always_ff @(posedge ref_clk_in) begin
        sclk_q <= serial_clk_in;
    end
    always_ff @(posedge ref_clk_in) begin
        if (rst_in || serial_select_n_in) begin
            bit_cnt <= 4'h0;
        end else if (sclk_q && !serial_clk_in) begin
            bit_cnt <= bit_cnt + 4'h1;
        end
    end
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            since16 <= 8'hFF;
        end else if (fell16) begin
            since16 <= 8'h00;
        end else if (since16 != 8'hFF) begin
            since16 <= since16 + 8'h01;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);
    write_due_a: assert property (disable iff (rst_in || reset_pin_in)
        fell16 |-> ##[25:33] reg_write_out)
        else $error("register write missing after sixteenth falling edge");
    write_window_a: assert property (reg_write_out
        |-> (since16 >= 8'h18) && (since16 <= 8'h20))
        else $error("register write without a complete word");
    write_pulse_a: assert property (reg_write_out |=> !reg_write_out)
        else $error("write strobe longer than one cycle");
    pdn_force_a: assert property (pdn_pin_in [*6] |-> global_pd_out)
        else $error("power-down pin did not force global power down");
    sync_strap_a: assert property ((strap_on && !serial_clk_in && serial_in_line_in) [*7]
        |-> pattern_out == acs_pkg::PAT_SYNC)
        else $error("sync pattern not selected by straps");
    deskew_strap_a: assert property ((strap_on && serial_clk_in && serial_in_line_in) [*7]
        |-> pattern_out == acs_pkg::PAT_DESKEW)
        else $error("deskew pattern not selected by straps");
    pd_strap_a: assert property ((strap_on && serial_clk_in && !serial_in_line_in) [*7]
        |-> global_pd_out)
        else $error("power down not selected by straps");
    ref_strap_a: assert property ((strap_on && select_level_in == acs_pkg::LVL_5_8) [*7]
        |-> internal_ref_out && coarse_gain_out)
        else $error("select strap decode wrong");
    format_strap_a: assert property (
        (strap_on && format_config_pin_in == acs_pkg::LVL_3_8) [*7]
        |-> !lsb_first_out && offset_binary_out)
        else $error("format strap decode wrong");
    pin_reset_a: assert property (reset_pin_in [*8] |-> !override_out && regs_reset_out)
        else $error("reset pin did not clear registers");
    word_seen_c: cover property (fell16);
    regs_clear_c: cover property (regs_reset_out);
    override_on_c: cover property ($rose(override_out));
endmodule : acs_config_asserts

bind acs_config acs_config_asserts chk_u (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .reset_pin_in(reset_pin_in),
    .serial_select_n_in(serial_select_n_in), .serial_clk_in(serial_clk_in),
    .serial_in_line_in(serial_in_line_in), .pdn_pin_in(pdn_pin_in),
    .select_level_in(select_level_in), .format_config_pin_in(format_config_pin_in),
    .global_pd_out(global_pd_out), .pattern_out(pattern_out),
    .internal_ref_out(internal_ref_out), .coarse_gain_out(coarse_gain_out),
    .lsb_first_out(lsb_first_out), .offset_binary_out(offset_binary_out),
    .override_out(override_out), .reg_write_out(reg_write_out),
    .regs_reset_out(regs_reset_out)
);
`default_nettype wire

// File: verification/acs_host_model.sv
// Purpose: Host controller that writes serial words and holds strap levels between frames
// Assumes: 48 ns serial clock period, phase unrelated to the reference clock
// Notes: Outside a frame the pins fall back to the strap resistor levels
`default_nettype none
module acs_host_model (
    input wire logic strap_clk_in,
    input wire logic strap_data_in,
    output logic serial_select_n_out,
    output logic serial_clk_out,
    output logic serial_in_line_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic in_frame = 1'b0;
    logic frame_clk = 1'b1;
    logic frame_data = 1'b0;
    initial serial_select_n_out = 1'b1;
    assign serial_clk_out = in_frame ? frame_clk : strap_clk_in;
    assign serial_in_line_out = in_frame ? frame_data : strap_data_in;
    task automatic start_frame(input logic hold_high);
        in_frame = 1'b1;
        frame_clk = 1'b1;
        #5.3;
        serial_select_n_out = hold_high;
        #25;
    endtask : start_frame
    // Address bits first, data launched after rise, sampled at the fall
    task automatic send(input logic [15:0] bits, input int count);
        for (int i = 0; i < count; i++) begin
            frame_data = bits[15 - i];
            #24 frame_clk = 1'b0;
            #24 frame_clk = 1'b1;
        end
    endtask : send
    task automatic end_frame();
        #25 serial_select_n_out = 1'b1;
        #5 in_frame = 1'b0;
    endtask : end_frame
endmodule : acs_host_model
`default_nettype wire

// File: verification/tb_top.sv
// Purpose: Self-checking bench for the strap decoder and serial register port
// Assumes: Straps driven as 2-bit level codes, serial pins from the host model
// Notes: Strap table first, then serial writes and both register resets
`default_nettype none
`define CHK(got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            bad_count++; \
            $display("Error t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rpin = 1'b0;
    logic pdn = 1'b0;
    logic strap_clk = 1'b0;
    logic strap_data = 1'b0;
    logic [1:0] sel_lvl = 2'h0;
    logic [1:0] link = 2'h0;
    logic [1:0] serc = 2'h0;
    logic [1:0] fmt = 2'h0;
    wire logic sel_n;
    wire logic sclk;
    wire logic serial_in_line;
    logic gpd, iref, coarse, ddr, two, s14, rise, lsb, offs, bytew, ovr, wr, rr, rr_q;
    logic [3:0] chpd;
    logic [2:0] pat;
    logic [11:0] strap_view;
    assign strap_view = {pat, gpd, iref, coarse, ddr, two, s14, rise, lsb, offs};
    logic [3:0] wr_count = 4'h0;
    logic [3:0] rr_count = 4'h0;
    int bad_count = 0;
    int check_count = 0;
    int cycles = 0;
    // Strap inputs {pdn, clk, data, sel, link, ser, fmt} and decoded outputs
    logic [22:0] rows [8] = '{23'h000020, 23'h155261, 23'h3A24D3, 23'h2E719A,
        23'h02801C, 23'h02C014, 23'h038030, 23'h400120};
    always #2 clk = ~clk;
    acs_host_model host_u (.strap_clk_in(strap_clk), .strap_data_in(strap_data),
        .serial_select_n_out(sel_n), .serial_clk_out(sclk), .serial_in_line_out(serial_in_line));
    acs_config dut_u (.ref_clk_in(clk), .rst_in(rst), .reset_pin_in(rpin),
        .serial_select_n_in(sel_n), .serial_clk_in(sclk), .serial_in_line_in(serial_in_line),
        .pdn_pin_in(pdn), .select_level_in(sel_lvl), .link_config_pin_in(link),
        .serialization_config_pin_in(serc), .format_config_pin_in(fmt),
        .global_pd_out(gpd), .chan_pd_out(chpd), .pattern_out(pat), .internal_ref_out(iref),
        .coarse_gain_out(coarse), .ddr_clk_out(ddr), .two_wire_out(two), .ser14_out(s14),
        .rise_capture_out(rise), .lsb_first_out(lsb), .offset_binary_out(offs),
        .byte_wise_out(bytew), .override_out(ovr), .reg_write_out(wr), .regs_reset_out(rr));
    always @(posedge clk) begin
        rr_q <= rr;
        if (wr === 1'b1) wr_count <= wr_count + 4'h1;
        if (rr === 1'b1 && rr_q !== 1'b1) rr_count <= rr_count + 4'h1;
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            bad_count++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks=%0d errors=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize
    task automatic wr_word(input logic [15:0] w);
        host_u.start_frame(1'b0);
        host_u.send(w, 16);
        host_u.end_frame();
        repeat (40) @(posedge clk);
    endtask : wr_word
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        `CHK({strap_view, chpd, ovr, bytew}, {12'h020, 6'h00})
        for (int i = 0; i < 8; i++) begin
            {pdn, strap_clk, strap_data, sel_lvl, link, serc, fmt} <= rows[i][22:12];
            repeat (10) @(posedge clk);
            `CHK(strap_view, rows[i][11:0])
        end
        {pdn, strap_clk, strap_data, sel_lvl, link, serc, fmt} <= 11'h000;
        repeat (10) @(posedge clk);
        host_u.start_frame(1'b1);
        host_u.send(16'h6CF6, 16);
        host_u.end_frame();
        repeat (40) @(posedge clk);
        `CHK({ovr, wr_count}, {1'b0, 4'h0})
        wr_word(16'h6CF6);
        `CHK({ovr, bytew, lsb, coarse, rise, s14, ddr, two}, 8'hF5)
        `CHK(wr_count, 4'h1)
        host_u.start_frame(1'b0);
        host_u.send(16'h5240, 16);
        host_u.send(16'h0034, 16);
        host_u.send(16'hF800, 5);
        host_u.end_frame();
        repeat (40) @(posedge clk);
        `CHK({pat, offs, iref, chpd, gpd, wr_count}, {10'h174, 4'h3})
        fmt <= 2'h3;
        pdn <= 1'b1;
        repeat (10) @(posedge clk);
        `CHK({lsb, offs, gpd}, 3'h7)
        pdn <= 1'b0;
        fmt <= 2'h0;
        wr_word(16'h0400);
        `CHK({ovr, chpd, pat, rr_count}, {1'b0, 4'h0, 3'h0, 4'h1})
        wr_word(16'h6CF6);
        rpin <= 1'b1;
        repeat (2) @(posedge clk);
        rpin <= 1'b0;
        repeat (10) @(posedge clk);
        `CHK(ovr, 1'b1)
        rpin <= 1'b1;
        repeat (10) @(posedge clk);
        rpin <= 1'b0;
        repeat (10) @(posedge clk);
        `CHK({ovr, rr_count}, {1'b0, 4'h2})
        summarize();
    end
endmodule : tb_top
`default_nettype wire
